//--- rtl/lae_pkg.sv
// Constants, field layouts and carrier types for the AND execute unit
//
// Notes on behaviour
// - Register-form AND decodes from top six bits 110000 with its seven fields.
// - Register form writes first source AND second source into destination.
// - Register form carries the wraparound select field through to the result.
// - Neither AND form alters the overflow flag.
// - Immediate form decodes from 110100; no wraparound or always-execute fields.
// - The 10-bit immediate is sign-extended to 32 bits before use.
// - Immediate form ANDs bit by bit and writes the destination.
// - Both forms branch on the result and may update linked fast memory.
package lae_pkg;

	// ----------------------------------------------------------------
	// Widths and opcodes
	// ----------------------------------------------------------------
	localparam int         XLEN        = 32;
	localparam int         IMM_W       = 10;
	localparam int         REG_CNT     = 64;
	localparam int         RA_W        = 6;
	localparam logic [5:0] OPC_AND_REG = 6'h30;
	localparam logic [5:0] OPC_AND_IMM = 6'h34;

	// ----------------------------------------------------------------
	// Branch condition codes, evaluated on the ALU result
	// ----------------------------------------------------------------
	localparam logic [3:0] ABC_NONE    = 4'h0;
	localparam logic [3:0] ABC_ZERO    = 4'h1;
	localparam logic [3:0] ABC_NZERO   = 4'h2;
	localparam logic [3:0] ABC_NEG     = 4'h3;
	localparam logic [3:0] ABC_NONNEG  = 4'h4;
	localparam logic [3:0] ABC_ALWAYS  = 4'h5;

	// ----------------------------------------------------------------
	// Instruction word as laid out for the register form; the
	// immediate form reuses the low ten bits as its operand
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [5:0] opcode;
		logic [4:0] rd;
		logic       memory_update_select;
		logic [3:0] abc;
		logic [5:0] rsa;
		logic [3:0] wraparound_arith_select;
		logic       always_exec_flag;
		logic [4:0] rsb;
	} lae_instr_t;

	// Result group handed to the rest of the core
	typedef struct packed {
		logic            valid;
		logic [4:0]      rd;
		logic [XLEN-1:0] data;
		logic            branch;
		logic            mem_upd;
		logic [3:0]      wraparound_arith_select;
	} lae_result_t;

endpackage

//--- rtl/lae_and_exec.sv
// Decode and single-cycle execute of the register and immediate AND forms
`timescale 1ns/1ns
module lae_and_exec
	import lae_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Instruction issue
	input  wire logic              issue_valid,
	input  wire logic [XLEN-1:0]   issue_instr,
	input  wire logic              issue_squash,
	// Register load port from the rest of the core
	input  wire logic              load_en,
	input  wire logic [RA_W-1:0]   load_addr,
	input  wire logic [XLEN-1:0]   load_data,
	// Overflow updates from other ALU instructions
	input  wire logic              ovf_wr_en,
	input  wire logic              ovf_wr_val,
	// Results
	output lae_result_t            exec_out,
	output logic                   ovf_flag,
	output logic                   unsupported
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Branch decision on the result; unknown codes never branch
	function automatic logic abc_taken(input logic [3:0] abc, input logic [XLEN-1:0] res);
		logic t;
		t = 1'b0;
		if (abc == ABC_ZERO) begin
			t = (res == '0);
		end else if (abc == ABC_NZERO) begin
			t = (res != '0);
		end else if (abc == ABC_NEG) begin
			t = res[XLEN-1];
		end else if (abc == ABC_NONNEG) begin
			t = ~res[XLEN-1];
		end else if (abc == ABC_ALWAYS) begin
			t = 1'b1;
		end
		return t;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [XLEN-1:0] rf_q [REG_CNT];
	lae_result_t     exec_r;
	lae_result_t     exec_nxt;
	logic            ovf_r;
	logic            ovf_nxt;
	logic            unsup_r;
	logic            unsup_nxt;

	lae_instr_t      fld;
	logic            is_reg;
	logic            is_imm;
	logic            fire;
	logic [XLEN-1:0] opa_w;
	logic [XLEN-1:0] opb_w;
	logic [XLEN-1:0] res_w;
	logic [RA_W-1:0] wr_addr;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Squash annuls a shadow slot; only the register form may override it
	assign fld    = lae_instr_t'(issue_instr);
	assign is_reg = (fld.opcode == OPC_AND_REG);
	assign is_imm = (fld.opcode == OPC_AND_IMM);
	assign fire   = issue_valid && (is_reg || is_imm)
	                && (!issue_squash || (is_reg && fld.always_exec_flag));
	assign wr_addr = {1'b0, fld.rd};

	// Operand selection; immediate is sign-extended from bit 9
	always_comb begin
		opa_w = rf_q[fld.rsa];
		if (is_imm) begin
			opb_w = {{(XLEN-IMM_W){issue_instr[IMM_W-1]}},
			         issue_instr[IMM_W-1:0]};
		end else begin
			opb_w = rf_q[{1'b0, fld.rsb}];
		end
	end

	// One full-width AND; wraparound has no effect on a bitwise result
	assign res_w = opa_w & opb_w;

	// ----------------------------------------------------------------
	// Next values of the result group and flags
	// ----------------------------------------------------------------
	always_comb begin
		exec_nxt       = '0;
		exec_nxt.valid = fire;
		exec_nxt.rd    = fld.rd;
		exec_nxt.data  = res_w;
		if (fire) begin
			exec_nxt.branch  = abc_taken(fld.abc, res_w);
			exec_nxt.mem_upd = fld.memory_update_select;
			if (is_reg) begin
				exec_nxt.wraparound_arith_select = fld.wraparound_arith_select;
			end
		end
		unsup_nxt = issue_valid && !is_reg && !is_imm;
		// AND never writes the flag; only other instructions do
		ovf_nxt = ovf_wr_en ? ovf_wr_val : ovf_r;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			exec_r  <= '0;
			ovf_r   <= 1'b0;
			unsup_r <= 1'b0;
		end else begin
			exec_r  <= exec_nxt;
			ovf_r   <= ovf_nxt;
			unsup_r <= unsup_nxt;
		end
	end

	// Register file: the AND write comes last so it wins over a load
	always_ff @(posedge core_clk) begin
		if (load_en) begin
			rf_q[load_addr] <= load_data;
		end
		if (fire && !rst) begin
			rf_q[wr_addr] <= res_w;
		end
	end

	assign exec_out    = exec_r;
	assign ovf_flag    = ovf_r;
	assign unsupported = unsup_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_reg_form_decode: assert property (
		@(posedge core_clk) disable iff (rst)
		(issue_valid && issue_instr[31:26] == 6'h30 && !issue_squash)
		|=> exec_out.valid)
		else $error("register-form AND not executed");

	a_reg_form_result: assert property (
		@(posedge core_clk) disable iff (rst)
		(fire && is_reg) |=> (exec_out.data ==
			($past(rf_q[issue_instr[15:10]]) & $past(rf_q[{1'b0, issue_instr[4:0]}]))))
		else $error("register-form AND result wrong");

	a_wrap_select_pass: assert property (
		@(posedge core_clk) disable iff (rst)
		(fire && is_reg) |=> (exec_out.wraparound_arith_select == $past(issue_instr[9:6])))
		else $error("wraparound select not carried");

	a_ovf_untouched: assert property (
		@(posedge core_clk) disable iff (rst)
		(fire && !ovf_wr_en) |=> $stable(ovf_flag))
		else $error("AND changed overflow flag");

	a_imm_form_decode: assert property (
		@(posedge core_clk) disable iff (rst)
		(issue_valid && issue_instr[31:26] == 6'h34 && !issue_squash)
		|=> (exec_out.valid && exec_out.wraparound_arith_select == 4'h0))
		else $error("immediate-form AND not executed");

	a_imm_sign_ext: assert property (
		@(posedge core_clk) disable iff (rst)
		is_imm |-> (issue_instr[9] ? (&opb_w[31:10]) : (opb_w[31:10] == '0)))
		else $error("immediate not sign-extended");

	a_imm_form_result: assert property (
		@(posedge core_clk) disable iff (rst)
		(fire && is_imm) |=> (exec_out.data ==
			($past(rf_q[issue_instr[15:10]]) & $past({{22{issue_instr[9]}}, issue_instr[9:0]}))))
		else $error("immediate-form AND result wrong");

	a_mem_upd_branch: assert property (
		@(posedge core_clk) disable iff (rst)
		(fire && issue_instr[20] && issue_instr[19:16] == ABC_ALWAYS)
		|=> (exec_out.mem_upd && exec_out.branch))
		else $error("memory update or branch missing");

	a_dest_written: assert property (
		@(posedge core_clk) disable iff (rst)
		exec_out.valid |-> (rf_q[{1'b0, exec_out.rd}] == exec_out.data))
		else $error("destination register not written");

	// Refusals are checked from the raw word so a broken decode cannot hide them
	a_foreign_refused: assert property (
		@(posedge core_clk) disable iff (rst)
		(issue_valid && issue_instr[31:26] != 6'h30 && issue_instr[31:26] != 6'h34)
		|=> (unsupported && !exec_out.valid))
		else $error("foreign opcode not refused");

	a_squash_override: assert property (
		@(posedge core_clk) disable iff (rst)
		(issue_valid && issue_squash && issue_instr[31:26] == 6'h30 && issue_instr[5])
		|=> exec_out.valid)
		else $error("always-execute slot not executed");

	a_squash_annuls: assert property (
		@(posedge core_clk) disable iff (rst)
		(issue_squash && !(issue_instr[31:26] == 6'h30 && issue_instr[5]))
		|=> !exec_out.valid)
		else $error("squashed slot executed");

	a_mem_upd_mirror: assert property (
		@(posedge core_clk) disable iff (rst)
		fire |=> (exec_out.mem_upd == $past(issue_instr[20])))
		else $error("memory update request not mirrored");

	a_branch_on_sign: assert property (
		@(posedge core_clk) disable iff (rst)
		(fire && issue_instr[19:16] == ABC_NEG)
		|=> (exec_out.branch == exec_out.data[31]))
		else $error("sign branch wrong");

	a_branch_on_zero: assert property (
		@(posedge core_clk) disable iff (rst)
		(fire && issue_instr[19:16] == ABC_ZERO)
		|=> (exec_out.branch == (exec_out.data == '0)))
		else $error("zero branch wrong");

endmodule

//--- sim/test_logical_and_instruction_exec.sv
// Self-checking bench for the register and immediate AND execute unit
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	$display("MISMATCH %s exp %h got %h", nm, e, g); bad_count++; end end
module test_logical_and_instruction_exec
	import lae_pkg::*;
;
	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic            core_clk = 1'b0;
	logic            rst = 1'b1;
	logic            issue_valid = 1'b0;
	logic [XLEN-1:0] issue_instr = '0;
	logic            issue_squash = 1'b0;
	logic            load_en = 1'b0;
	logic [RA_W-1:0] load_addr = '0;
	logic [XLEN-1:0] load_data = '0;
	logic            ovf_wr_en = 1'b0;
	logic            ovf_wr_val = 1'b0;
	lae_result_t     exec_out;
	logic            ovf_flag;
	logic            unsupported;
	int              bad_count = 0;
	int              n_checks = 0;

	always #5 core_clk = ~core_clk;

	lae_and_exec i_dut (.core_clk(core_clk), .rst(rst), .issue_valid(issue_valid),
		.issue_instr(issue_instr), .issue_squash(issue_squash), .load_en(load_en),
		.load_addr(load_addr), .load_data(load_data), .ovf_wr_en(ovf_wr_en),
		.ovf_wr_val(ovf_wr_val), .exec_out(exec_out), .ovf_flag(ovf_flag),
		.unsupported(unsupported));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Low ten bits carry wraparound select, always-execute and second source for the
	// register form, and the immediate operand for the immediate form
	function automatic logic [31:0] mk(logic [5:0] op, logic [4:0] rd, logic mus,
		logic [3:0] abc, logic [5:0] rsa, logic [9:0] lo);
		return {op, rd, mus, abc, rsa, lo};
	endfunction

	task automatic load(input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk) begin load_en <= 1'b1; load_addr <= a; load_data <= d; end
		@(posedge core_clk) load_en <= 1'b0;
	endtask

	// Result is sampled 1 ns into the cycle after the taking edge, where it stands
	task automatic issue(input logic [31:0] ins, input logic sq);
		@(posedge core_clk) begin issue_valid <= 1'b1; issue_instr <= ins; issue_squash <= sq; end
		@(posedge core_clk) begin issue_valid <= 1'b0; issue_squash <= 1'b0; end
		#1;
	endtask

	task automatic set_ovf(input logic v);
		@(posedge core_clk) begin ovf_wr_en <= 1'b1; ovf_wr_val <= v; end
		@(posedge core_clk) ovf_wr_en <= 1'b0;
		#1;
		`CHK("ovf_flag", v, ovf_flag)
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Register form, then the result reused as an operand
	task automatic t_reg();
		issue(mk(OPC_AND_REG, 5'h04, 1'b1, ABC_NZERO, 6'h01, {4'hA, 1'b0, 5'h02}), 1'b0);
		`CHK("valid", 1'b1, exec_out.valid)
		`CHK("rd", 5'h04, exec_out.rd)
		`CHK("data", 32'h00F0_1200, exec_out.data)
		`CHK("wrap_sel", 4'hA, exec_out.wraparound_arith_select)
		`CHK("mem_upd", 1'b1, exec_out.mem_upd)
		`CHK("br_nzero", 1'b1, exec_out.branch)
		issue(mk(OPC_AND_REG, 5'h05, 1'b0, ABC_ZERO, 6'h04, {4'h0, 1'b0, 5'h03}), 1'b0);
		`CHK("rd_wb", 32'h00F0_1200, exec_out.data)
		`CHK("mem_upd0", 1'b0, exec_out.mem_upd)
		`CHK("br_zero0", 1'b0, exec_out.branch)
		// Look one cycle on, clear of the edge that moves the output
		@(posedge core_clk);
		#1;
		`CHK("valid_end", 1'b0, exec_out.valid)
	endtask

	// Every branch code on a negative non-zero result, linked update asked throughout
	task automatic t_abc();
		logic [5:0] taken;
		taken = 6'h2C;
		for (int c = 0; c < 6; c++) begin
			issue(mk(OPC_AND_REG, 5'h06, 1'b1, 4'(c), 6'h01, {4'h0, 1'b0, 5'h03}), 1'b0);
			`CHK("branch", taken[c], exec_out.branch)
			`CHK("data32", 32'hF0F0_1234, exec_out.data)
			`CHK("abc_upd", 1'b1, exec_out.mem_upd)
		end
		// Only a zero result takes the zero branch
		issue(mk(OPC_AND_IMM, 5'h06, 1'b0, ABC_ZERO, 6'h02, 10'h0FF), 1'b0);
		`CHK("br_zero", 1'b1, exec_out.branch)
		`CHK("zero_data", 32'h0000_0000, exec_out.data)
	endtask

	// Immediate form with both signs of the operand and an upper source index
	task automatic t_imm();
		issue(mk(OPC_AND_IMM, 5'h07, 1'b1, ABC_NEG, 6'h03, 10'h200), 1'b0);
		`CHK("imm_neg", 32'hFFFF_FE00, exec_out.data)
		`CHK("imm_br", 1'b1, exec_out.branch)
		`CHK("imm_upd", 1'b1, exec_out.mem_upd)
		`CHK("imm_wrap", 4'h0, exec_out.wraparound_arith_select)
		issue(mk(OPC_AND_IMM, 5'h08, 1'b0, ABC_NONE, 6'h28, 10'h1FF), 1'b0);
		`CHK("imm_pos", 32'h0000_0078, exec_out.data)
		`CHK("imm_rd", 5'h08, exec_out.rd)
	endtask

	// Overflow flag survives both forms at either value
	task automatic t_ovf();
		for (int v = 0; v < 2; v++) begin
			set_ovf(1'(~v));
			issue(mk(OPC_AND_REG, 5'h09, 1'b0, ABC_NONE, 6'h01, 10'h002), 1'b0);
			`CHK("ovf_reg", 1'(~v), ovf_flag)
			issue(mk(OPC_AND_IMM, 5'h09, 1'b0, ABC_NONE, 6'h01, 10'h3FF), 1'b0);
			`CHK("ovf_imm", 1'(~v), ovf_flag)
		end
	endtask

	// Foreign opcode and squashed slots; always-execute rescues only the register form
	task automatic t_refuse();
		issue(mk(6'h31, 5'h04, 1'b0, ABC_NONE, 6'h03, 10'h003), 1'b0);
		`CHK("unsup", 1'b1, unsupported)
		`CHK("unsup_v", 1'b0, exec_out.valid)
		issue(mk(OPC_AND_REG, 5'h0A, 1'b0, ABC_NONE, 6'h03, {4'h0, 1'b1, 5'h03}), 1'b1);
		`CHK("rescue_v", 1'b1, exec_out.valid)
		`CHK("rescue_data", 32'hFFFF_FFFF, exec_out.data)
		issue(mk(OPC_AND_REG, 5'h0A, 1'b0, ABC_NONE, 6'h01, {4'h0, 1'b0, 5'h03}), 1'b1);
		`CHK("sq_reg", 1'b0, exec_out.valid)
		issue(mk(OPC_AND_IMM, 5'h0A, 1'b0, ABC_NONE, 6'h03, 10'h020), 1'b1);
		`CHK("sq_imm", 1'b0, exec_out.valid)
		`CHK("sq_unsup", 1'b0, unsupported)
		// Neither squashed slot may have touched the destination
		issue(mk(OPC_AND_REG, 5'h0C, 1'b0, ABC_NONE, 6'h0A, {4'h0, 1'b0, 5'h03}), 1'b0);
		`CHK("sq_keep", 32'hFFFF_FFFF, exec_out.data)
	endtask

	// ----------------------------------------------------------------
	// Main sequence, watchdog and verdict
	// ----------------------------------------------------------------
	task automatic summarize();
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		load(6'h01, 32'hF0F0_1234);
		load(6'h02, 32'h0FF0_FF00);
		load(6'h03, 32'hFFFF_FFFF);
		load(6'h28, 32'h1234_5678);
		t_reg();
		t_abc();
		t_imm();
		t_ovf();
		t_refuse();
		summarize();
	end

	// Whole run is about 61 cycles; this allows ample margin
	initial begin
		#20000;
		bad_count++;
		summarize();
	end
endmodule
